// ---- rtl/crs_defs.svh ----
/*
  crs_defs.svh: offsets, field positions, reset values and timing counts
  for the clock and reset sequencer.
  Assumes inclusion by bare name from any file that needs the constants.
*/
`ifndef CRS_DEFS_SVH
`define CRS_DEFS_SVH

// register indices on the plain register port
`define CRS_REG_POWER_MGMT_CTRL       4'h0
`define CRS_REG_POWER_MGMT_CTRL_ALIAS 4'h1
`define CRS_REG_STATUS      4'h2

// power_mgmt_ctrl fields
`define CRS_MUL_LSB         0
`define CRS_MUL_MSB         5
`define CRS_DIV_LSB         6
`define CRS_DIV_MSB         7
`define CRS_BYPASS_BIT      8
`define CRS_OUTSEL_BIT      12
`define CRS_POWER_MGMT_CTRL_MASK      32'h0000_11FF

// startup ratios decoded from clock_ratio_cfg_pins
`define CRS_MUL_CFG00       6'h06
`define CRS_MUL_CFG01       6'h20
`define CRS_MUL_CFG10       6'h10
`define CRS_DIV_RESET       2'h0

// lock wait in reference clock cycles
`define CRS_LOCK_CYCLES     4096

`endif

// ---- rtl/crs_pkg.sv ----
/*
  crs_pkg.sv: types shared by the clock and reset sequencer.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package crs_pkg;
  // gray coded along hold -> lock wait -> run
  typedef enum logic [1:0] {
    CRS_HOLD = 2'b00,
    CRS_LOCK = 2'b01,
    CRS_RUN  = 2'b11
  } crs_state_e;
endpackage

// ---- rtl/crs_sequencer.sv ----
/*
  crs_sequencer.sv: clock source selection, startup ratio, lock wait,
  core reset release and the shared reset/clock output pin.
  Assumes clock is the reference clock, reset is the asynchronous external
  reset already inverted to active high, and cfg pins are asynchronous.
*/
// The register offsets and strobed register access are this design's own decisions.
`timescale 1ns/100ps
`include "crs_defs.svh"

module crs_sequencer
  import crs_pkg::*;
#(
  parameter int LOCK_CYCLES = `CRS_LOCK_CYCLES
) (
  input  wire logic        clock,
  input  wire logic        reset,
  input  wire logic [1:0]  clock_ratio_cfg_pins,
  input  wire logic        pll_clock_in,
  input  wire logic [3:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_write,
  input  wire logic        reg_read,
  output logic      [31:0] reg_rdata,
  output logic             core_reset,
  output logic             core_fetch_vector,
  output logic             core_clock_sel_pll,
  output logic      [5:0]  pll_multiplier,
  output logic      [1:0]  pll_divider,
  output logic             reset_or_clock_out
);

  localparam int CW = $clog2(LOCK_CYCLES + 1);

  // two-flop synchroniser for the asynchronous config pins
  logic [1:0] cfg_meta_r;
  logic [1:0] cfg_sync_r;
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      cfg_meta_r <= 2'h0;
      cfg_sync_r <= 2'h0;
    end else begin
      cfg_meta_r <= clock_ratio_cfg_pins;
      cfg_sync_r <= cfg_meta_r;
    end
  end

  // startup ratio decode; 11 is undefined and runs on the raw reference
  logic [5:0] mul_dec;
  logic       bypass_dec;
  always_comb begin
    mul_dec    = `CRS_MUL_CFG00;
    bypass_dec = 1'b0;
    case (cfg_sync_r)
      2'b00: mul_dec = `CRS_MUL_CFG00;
      2'b01: mul_dec = `CRS_MUL_CFG01;
      2'b10: mul_dec = `CRS_MUL_CFG10;
      default: begin
        mul_dec    = 6'h01;
        bypass_dec = 1'b1;
      end
    endcase
  end

  // sequencer state and lock counter
  crs_state_e     state_r;
  logic [CW-1:0]  lock_cnt_r;
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      state_r    <= CRS_HOLD;
      lock_cnt_r <= '0;
    end else begin
      case (state_r)
        CRS_HOLD: begin
          // first clocked cycle after release: cfg_sync_r still holds its reset value
          state_r    <= CRS_LOCK;
          lock_cnt_r <= '0;
        end
        CRS_LOCK: begin
          if (lock_cnt_r == CW'(LOCK_CYCLES - 1))
            state_r <= CRS_RUN;
          lock_cnt_r <= lock_cnt_r + CW'(1);
        end
        CRS_RUN:  state_r <= CRS_RUN;
        default:  state_r <= CRS_HOLD;
      endcase
    end
  end

  // control register; pin-derived values are loaded until the core runs
  logic [5:0] mul_r;
  logic [1:0] div_r;
  logic       bypass_r;
  logic       outsel_r;
  logic       pm_wr;
  assign pm_wr = reg_write && state_r == CRS_RUN &&
                 (reg_addr == `CRS_REG_POWER_MGMT_CTRL ||
                  reg_addr == `CRS_REG_POWER_MGMT_CTRL_ALIAS);
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      mul_r    <= `CRS_MUL_CFG00;
      div_r    <= `CRS_DIV_RESET;
      bypass_r <= 1'b0;
      outsel_r <= 1'b0;
    end else if (state_r != CRS_RUN) begin
      mul_r    <= mul_dec;
      div_r    <= `CRS_DIV_RESET;
      bypass_r <= bypass_dec;
      outsel_r <= 1'b0;
    end else if (pm_wr) begin
      mul_r    <= reg_wdata[`CRS_MUL_MSB:`CRS_MUL_LSB];
      div_r    <= reg_wdata[`CRS_DIV_MSB:`CRS_DIV_LSB];
      bypass_r <= reg_wdata[`CRS_BYPASS_BIT];
      outsel_r <= reg_wdata[`CRS_OUTSEL_BIT];
    end
  end

  // register outputs straight from flops
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      core_reset         <= 1'b1;
      core_fetch_vector  <= 1'b0;
      core_clock_sel_pll <= 1'b0;
      pll_multiplier     <= `CRS_MUL_CFG00;
      pll_divider        <= `CRS_DIV_RESET;
    end else begin
      core_reset         <= state_r != CRS_RUN;
      // one-cycle pulse in the cycle core_reset falls; core_reset is
      // still high only on the first run edge, so the pulse cannot stretch
      core_fetch_vector  <= state_r == CRS_RUN && core_reset;
      core_clock_sel_pll <= ~bypass_r;
      pll_multiplier     <= mul_r;
      pll_divider        <= div_r;
    end
  end

  // shared pin: reset out by default, PLL clock when bit 12 set.
  // the clock path is a sampled copy since outputs come from flops; a
  // real chip would use a glitch-free mux cell here instead.
  always_ff @(posedge clock or posedge reset) begin
    if (reset)
      reset_or_clock_out <= 1'b1;
    else if (outsel_r)
      reset_or_clock_out <= pll_clock_in;
    else
      reset_or_clock_out <= state_r != CRS_RUN;
  end

  // read port, data one cycle after the strobe
  logic [31:0] pm_word;
  assign pm_word = {19'h0, outsel_r, 3'h0, bypass_r, div_r, mul_r};
  always_ff @(posedge clock or posedge reset) begin
    if (reset)
      reg_rdata <= 32'h0;
    else if (!reg_read)
      reg_rdata <= 32'h0;
    else if (reg_addr == `CRS_REG_POWER_MGMT_CTRL ||
             reg_addr == `CRS_REG_POWER_MGMT_CTRL_ALIAS)
      reg_rdata <= pm_word;
    else if (reg_addr == `CRS_REG_STATUS)
      reg_rdata <= {28'h0, cfg_sync_r, state_r};
    else
      reg_rdata <= 32'h0;
  end

endmodule // crs_sequencer

// ---- dv/crs_board_model.sv ----
/* crs_board_model.sv: board side, a locked pll clock source.
   Assumes a steady reference clock. */
`timescale 1ns/100ps
module crs_board_model (
  input  wire logic clock,
  output logic      pll_clock_in = 1'b0,
  output logic      test_reset_n = 1'b0,
  output logic      test_clock   = 1'b0
);
  // test reset and test clock are held low from power-up on the board
  // pll runs off the reference, which the board never stops
  always @(posedge clock) pll_clock_in <= ~pll_clock_in;
endmodule // crs_board_model

// ---- dv/crs_chk.sv ----
/* crs_chk.sv: port assertions for crs_sequencer.
   Assumes the bind below. */
`timescale 1ns/100ps
module crs_chk #(parameter int LOCK_CYCLES = 4096) (
  input wire logic        clock, reset, reg_write, core_reset,
  input wire logic        core_fetch_vector, reset_or_clock_out,
  input wire logic [1:0]  clock_ratio_cfg_pins, pll_divider,
  input wire logic [3:0]  reg_addr,
  input wire logic [5:0]  pll_multiplier,
  input wire logic [31:0] reg_wdata
);
  localparam logic [5:0] MUL [4] = '{6'h06, 6'h20, 6'h10, 6'h01};
  logic [31:0] hold_r; // edges held in core reset since release
  always_ff @(posedge clock or posedge reset) begin
    if (reset) hold_r <= 32'h0;
    else if (core_reset) hold_r <= hold_r + 32'h1;
  end
  default clocking @(posedge clock); endclocking
  default disable iff (reset);
  fetch_pulse_a: assert property (
    core_fetch_vector == $fell(core_reset)) else $error("bad fetch");
  fetch_once_a: assert property (
    core_fetch_vector |=> !core_fetch_vector) else $error("long fetch");
  lock_exact_a: assert property (
    $fell(core_reset) |-> hold_r == LOCK_CYCLES + 2) else $error("bad wait");
  lock_late_a: assert property (
    core_reset |-> hold_r <= LOCK_CYCLES + 1) else $error("late run");
  pin_reset_a: assert property (
    core_reset || $fell(core_reset) |-> reset_or_clock_out == core_reset)
    else $error("bad reset out");
  run_hold_a: assert property (
    !core_reset |=> !core_reset) else $error("core reset again");
  ratio_pins_a: assert property (
    (core_reset && $stable(clock_ratio_cfg_pins)) [*6]
    |-> pll_multiplier == MUL[clock_ratio_cfg_pins]) else $error("bad ratio");
  ctrl_write_a: assert property (
    reg_write && reg_addr[3:1] == 3'h0 && !core_reset
    |-> ##2 {pll_divider, pll_multiplier} == 8'($past(reg_wdata, 2)))
    else $error("write lost");
  cover property ($fell(core_reset));
  cover property (reg_write && !core_reset);
  cover property (core_reset && clock_ratio_cfg_pins == 2'h2);
endmodule // crs_chk
bind crs_sequencer crs_chk #(.LOCK_CYCLES(LOCK_CYCLES)) chk (.*);

// ---- dv/tb_top.sv ----
/* tb_top.sv: boots crs_sequencer per ratio, then drives its registers.
   Assumes a lock wait shortened to 8 cycles. */
`timescale 1ns/100ps
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin n_mismatch++; \
  $display("[FAIL] %0t got %h want %h", $time, a, e); end end
module tb_top;
  localparam int LC = 8; // short wait keeps the run brief
  logic clock = 1'b0, reset = 1'b1, reg_write = 1'b0, reg_read = 1'b0;
  logic [1:0] cfg = 2'h0, div;
  logic [3:0] reg_addr = 4'h0;
  logic [5:0] mul;
  logic [31:0] reg_wdata = 32'h0, reg_rdata;
  logic core_reset, fetch, sel_pll, rout, pll_clock_in, p;
  int n_mismatch = 0, checks = 0;
  logic [5:0] muls [3] = '{6'h06, 6'h20, 6'h10};
  always #50 clock = ~clock;
  crs_sequencer #(.LOCK_CYCLES(LC)) uut (.clock, .reset,
    .clock_ratio_cfg_pins(cfg), .pll_clock_in, .reg_addr, .reg_wdata,
    .reg_write, .reg_read, .reg_rdata, .core_reset,
    .core_fetch_vector(fetch), .core_clock_sel_pll(sel_pll),
    .pll_multiplier(mul), .pll_divider(div), .reset_or_clock_out(rout));
  crs_board_model board (.clock, .pll_clock_in, .test_reset_n(),
    .test_clock());
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clock);
    {reg_addr, reg_wdata, reg_write} <= {a, d, 1'b1};
    @(posedge clock);
    reg_write <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    @(posedge clock);
    {reg_addr, reg_read} <= {a, 1'b1};
    @(posedge clock);
    reg_read <= 1'b0;
    #1 `CHK(reg_rdata, e)
  endtask
  // early write must be ignored; release lands exactly after the wait
  task automatic boot(input logic [1:0] c);
    @(posedge clock);
    {reset, cfg} <= {1'b1, c};
    repeat (2) @(posedge clock);
    reset <= 1'b0;
    #1 `CHK({core_reset, rout, mul, div}, {8'hC6, 2'h0})
    wr(4'h0, 32'h0000_1000);
    repeat (LC - 1) @(posedge clock);
    #1 `CHK({core_reset, fetch}, 2'b10)
    @(posedge clock);
    #1 `CHK({core_reset, fetch, rout, sel_pll, mul}, {4'h5, muls[c]})
    rd(4'h0, {26'h0, muls[c]});
    rd(4'h2, {28'h0, c, 2'h3});
  endtask
  initial begin
    for (int i = 0; i < 3; i++) boot(2'(i));
    wr(4'h1, 32'h0000_104A);
    repeat (2) @(posedge clock);
    #1 `CHK({div, mul}, 8'h4A)
    repeat (2) begin
      p = pll_clock_in;
      @(posedge clock);
      #1 `CHK(rout, p)
    end
    rd(4'h7, 32'h0);
    boot(2'h1);
    print_verdict;
  end
  // a hang counts as a failure
  initial begin
    #100000;
    n_mismatch++;
    print_verdict;
  end
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
endmodule // tb_top
